// [verilog/brsc_defs.svh]
// Offset, field positions and reset values of the boot ROM select control register
`ifndef BRSC_DEFS_SVH
`define BRSC_DEFS_SVH

// Register offset inside the configuration region
`define BRSC_CTL_OFFSET 12'h050

// Field positions
`define BRSC_LOC_BIT 12
`define BRSC_WIDTH_HI 11
`define BRSC_WIDTH_LO 10
`define BRSC_MODE_BIT 9
`define BRSC_SUB_HI 5
`define BRSC_SUB_LO 4
`define BRSC_FIRST_HI 2
`define BRSC_FIRST_LO 0

// Reset values
`define BRSC_MODE_RST 1'h0
`define BRSC_SUB_RST 2'h3
`define BRSC_FIRST_RST 3'h7
`define BRSC_LOC_RST 1'h0
`define BRSC_WIDTH_RST 2'h0

`endif

// [verilog/brsc_pkg.sv]
// Types shared by the boot ROM select control block
package brsc_pkg;

	// Decoded boot device width
	typedef enum logic [1:0] {
		BRSC_W8,
		BRSC_W16,
		BRSC_W32
	} brsc_width_type;

	// Whole state of the control block
	typedef struct packed {
		logic pg_prev;
		logic loc;
		logic gp;
		logic [1:0] width;
		brsc_width_type width_dec;
		logic mode;
		logic [1:0] sub_dly;
		logic [2:0] first_dly;
		logic [15:0] rdata;
		logic ack;
		logic [2:0] wait_states;
		logic wait_valid;
	} brsc_state_type;

	// Width field to device width
	function automatic brsc_width_type brsc_decode_width(input logic [1:0] field);
		if (field == 2'h0) begin
			return BRSC_W8;
		end else if (field == 2'h1) begin
			return BRSC_W16;
		end else begin
			return BRSC_W32;
		end
	endfunction

endpackage

// [verilog/brsc_wait_sel.sv]
// Wait state selector for one boot ROM access
`timescale 1ns/100ps

module brsc_wait_sel (
	input wire logic page_mode,
	input wire logic first_access,
	input wire logic [1:0] sub_dly,
	input wire logic [2:0] first_dly,
	output logic [2:0] wait_states
);

	// Subsequent delay only for later page accesses
	always_comb begin
		if (page_mode && !first_access) begin
			wait_states = {1'h0, sub_dly};
		end else begin
			wait_states = first_dly;
		end
	end

endmodule

// [verilog/brsc_top.sv]
// Boot ROM select control register with strap capture and wait selection
`timescale 1ns/100ps
`include "brsc_defs.svh"

module brsc_top (
	input wire logic ref_clk,
	input wire logic nrst,
	// Straps and power good
	input wire logic power_good_input,
	input wire logic location_strap_pin,
	input wire logic width_strap_high,
	input wire logic width_strap_low,
	// Register port
	input wire logic cfg_sel,
	input wire logic cfg_write,
	input wire logic [11:0] cfg_addr,
	input wire logic [1:0] cfg_be,
	input wire logic [15:0] cfg_wdata,
	output logic [15:0] cfg_rdata,
	output logic cfg_ack,
	// Settings toward the ROM sequencer
	output logic boot_on_sdram,
	output logic boot_on_gp,
	output brsc_pkg::brsc_width_type boot_width,
	output logic page_mode,
	output logic [1:0] subsequent_delay_field,
	output logic [2:0] first_delay_field,
	// Per access wait state lookup
	input wire logic access_req,
	input wire logic access_first,
	output logic [2:0] wait_states,
	output logic wait_valid
);

	////////////////////////////////////////////////////////////////////////
	// State and next state

	brsc_pkg::brsc_state_type st; // Registered state
	brsc_pkg::brsc_state_type next_st; // Next state
	logic pg_rise; // Power good just asserted
	logic hit; // Access addresses this register
	logic [2:0] sel_waits; // Wait count for current access

	assign pg_rise = power_good_input && !st.pg_prev;
	assign hit = cfg_sel && (cfg_addr == `BRSC_CTL_OFFSET);

	// Wait state choice
	brsc_wait_sel u_wait_sel (
		.page_mode(st.mode),
		.first_access(access_first),
		.sub_dly(st.sub_dly),
		.first_dly(st.first_dly),
		.wait_states(sel_waits)
	);

	////////////////////////////////////////////////////////////////////////
	// Next state logic

	// Strap capture, register writes, reads and wait lookup
	always_comb begin
		next_st = st;
		next_st.pg_prev = power_good_input;
		next_st.ack = cfg_sel;
		next_st.wait_valid = access_req;
		// Straps latched only at power good rising
		if (pg_rise) begin
			next_st.loc = location_strap_pin;
			next_st.gp = !location_strap_pin;
			next_st.width = {width_strap_high, width_strap_low};
			next_st.width_dec = brsc_pkg::brsc_decode_width({width_strap_high, width_strap_low});
		end
		// Writes touch mode and delays only
		if (hit && cfg_write) begin
			if (cfg_be[1]) begin
				next_st.mode = cfg_wdata[`BRSC_MODE_BIT];
			end
			if (cfg_be[0]) begin
				next_st.sub_dly = cfg_wdata[`BRSC_SUB_HI:`BRSC_SUB_LO];
				next_st.first_dly = cfg_wdata[`BRSC_FIRST_HI:`BRSC_FIRST_LO];
			end
			// Location and width have no write path
		end
		// Read data, reserved bits zero
		if (hit && !cfg_write) begin
			next_st.rdata = 16'h0000;
			next_st.rdata[`BRSC_LOC_BIT] = st.loc;
			next_st.rdata[`BRSC_WIDTH_HI:`BRSC_WIDTH_LO] = st.width;
			next_st.rdata[`BRSC_MODE_BIT] = st.mode;
			next_st.rdata[`BRSC_SUB_HI:`BRSC_SUB_LO] = st.sub_dly;
			next_st.rdata[`BRSC_FIRST_HI:`BRSC_FIRST_LO] = st.first_dly;
		end else if (cfg_sel) begin
			// Unmapped address or write reads zero
			next_st.rdata = 16'h0000;
		end
		// Wait count for the requested access
		if (access_req) begin
			next_st.wait_states = sel_waits;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	// Reset loads constants only
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st.pg_prev <= 1'h0;
			st.loc <= `BRSC_LOC_RST;
			st.gp <= ~`BRSC_LOC_RST;
			st.width <= `BRSC_WIDTH_RST;
			st.width_dec <= brsc_pkg::BRSC_W8;
			st.mode <= `BRSC_MODE_RST;
			st.sub_dly <= `BRSC_SUB_RST;
			st.first_dly <= `BRSC_FIRST_RST;
			st.rdata <= 16'h0000;
			st.ack <= 1'h0;
			st.wait_states <= 3'h0;
			st.wait_valid <= 1'h0;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from the state register

	assign cfg_rdata = st.rdata;
	assign cfg_ack = st.ack;
	assign boot_on_sdram = st.loc;
	assign boot_on_gp = st.gp;
	assign boot_width = st.width_dec;
	assign page_mode = st.mode;
	assign subsequent_delay_field = st.sub_dly;
	assign first_delay_field = st.first_dly;
	assign wait_states = st.wait_states;
	assign wait_valid = st.wait_valid;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	// Location captured at power good
	property p_loc_capture;
		$rose(power_good_input) |=> (boot_on_sdram == $past(location_strap_pin));
	endproperty
	a_loc_capture: assert property (p_loc_capture) else $error("location not captured");

	// Bus select outputs agree with readback
	property p_loc_meaning;
		(cfg_ack && !$past(cfg_write) && $past(cfg_addr) == `BRSC_CTL_OFFSET)
			|-> (cfg_rdata[`BRSC_LOC_BIT] == $past(boot_on_sdram)) && (boot_on_gp != boot_on_sdram);
	endproperty
	a_loc_meaning: assert property (p_loc_meaning) else $error("bus select mismatch");

	// Width captured at power good
	property p_width_capture;
		$rose(power_good_input) |=> (st.width == {$past(width_strap_high), $past(width_strap_low)});
	endproperty
	a_width_capture: assert property (p_width_capture) else $error("width not captured");

	// Width decode
	property p_width_decode;
		(st.width == 2'h0 && boot_width == brsc_pkg::BRSC_W8)
			|| (st.width == 2'h1 && boot_width == brsc_pkg::BRSC_W16)
			|| (st.width[1] && boot_width == brsc_pkg::BRSC_W32);
	endproperty
	a_width_decode: assert property (p_width_decode) else $error("width decode wrong");

	// Mode follows a write to the high byte
	property p_mode_write;
		(hit && cfg_write && cfg_be[1]) |=> (page_mode == $past(cfg_wdata[`BRSC_MODE_BIT]));
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("mode not written");

	// Later page access uses subsequent delay
	property p_sub_wait;
		(access_req && !access_first && page_mode) |=> wait_valid && (wait_states == {1'h0, $past(st.sub_dly)});
	endproperty
	a_sub_wait: assert property (p_sub_wait) else $error("subsequent wait wrong");

	// First or non-page access uses first delay
	property p_first_wait;
		(access_req && (access_first || !page_mode)) |=> wait_valid && (wait_states == $past(st.first_dly));
	endproperty
	a_first_wait: assert property (p_first_wait) else $error("first wait wrong");

	// Strapped bits stand still outside power good
	property p_strap_hold;
		!$rose(power_good_input) |=> $stable(st.loc) && $stable(st.width);
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("strapped bits changed");

	// Values after reset release
	property p_reset_values;
		$rose(nrst) |-> (page_mode == 1'h0) && (subsequent_delay_field == 2'h3) && (first_delay_field == 3'h7);
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

	// Bus select outputs always complementary
	property p_gp_inverse;
		boot_on_gp != boot_on_sdram;
	endproperty
	a_gp_inverse: assert property (p_gp_inverse) else $error("bus select outputs not complementary");

	// No wait answer without a request
	property p_wait_pulse;
		!access_req |=> !wait_valid;
	endproperty
	a_wait_pulse: assert property (p_wait_pulse) else $error("wait answer without request");

	// Every register access answered next cycle
	property p_ack_pulse;
		cfg_sel |=> cfg_ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("register access not answered");

	// Reserved bits always read as zero
	property p_reserved_zero;
		cfg_ack |-> ((cfg_rdata & 16'hE1C8) == 16'h0000);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

endmodule

// [verification/brsc_strap_model.sv]
// Board straps and supply monitor seen by the boot select block
`timescale 1ns/100ps

module brsc_strap_model (
	input wire logic ref_clk,
	input wire logic pg_on,
	input wire logic [2:0] strap_set,
	output logic power_good_input,
	output logic location_strap_pin,
	output logic width_strap_high,
	output logic width_strap_low
);
	// Supply low and straps low at power-on
	initial begin
		power_good_input = 1'h0;
		{location_strap_pin, width_strap_high, width_strap_low} = 3'h0;
	end
	// Levels taken at the edge, settle a little after it
	always @(posedge ref_clk) begin
		power_good_input <= #2 pg_on;
		{location_strap_pin, width_strap_high, width_strap_low} <= #2 strap_set;
	end
endmodule

// [verification/boot_rom_select_config_test.sv]
// Self-checking bench for the boot ROM select control block
`timescale 1ns/100ps

module boot_rom_select_config_test;
	logic ref_clk = 0, nrst = 0, pg_on = 0, cfg_sel = 0, cfg_write = 0, access_req = 0, access_first = 0;
	logic [2:0] strap_set = 0;
	logic [11:0] cfg_addr = 0;
	logic [1:0] cfg_be = 0;
	logic [15:0] cfg_wdata = 0, cfg_rdata, d;
	logic cfg_ack, boot_on_sdram, boot_on_gp, page_mode, wait_valid;
	logic power_good_input, location_strap_pin, width_strap_high, width_strap_low;
	brsc_pkg::brsc_width_type boot_width;
	logic [1:0] subsequent_delay_field, m_w = 0, m_sub = 3;
	logic [2:0] first_delay_field, wait_states, m_first = 7;
	logic m_loc = 0, m_mode = 0;
	logic [15:0] reg_q[$], wait_q[$];
	logic [7:0] rnd = 8'h16;
	int mismatches = 0, checks_done = 0;

	always #10 ref_clk = ~ref_clk;

	brsc_strap_model straps (.ref_clk, .pg_on, .strap_set, .power_good_input, .location_strap_pin,
		.width_strap_high, .width_strap_low);
	brsc_top uut (.ref_clk, .nrst, .power_good_input, .location_strap_pin, .width_strap_high,
		.width_strap_low, .cfg_sel, .cfg_write, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack,
		.boot_on_sdram, .boot_on_gp, .boot_width, .page_mode, .subsequent_delay_field, .first_delay_field,
		.access_req, .access_first, .wait_states, .wait_valid);

	////////////////////////////////////////////////////////////////
	// Random source
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	// Expected register image
	function automatic logic [15:0] img();
		return {3'h0, m_loc, m_w, m_mode, 3'h0, m_sub, 1'h0, m_first};
	endfunction
	task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// Register read data against a note
	task automatic check_read(input logic [15:0] e);
		check("cfg_rdata", e, cfg_rdata);
	endtask
	// Wait count against a note
	task automatic check_wait(input logic [15:0] e);
		check("wait_states", e, 16'(wait_states));
	endtask
	task automatic tick();
		@(posedge ref_clk);
		#2;
	endtask
	// One register cycle, then an idle cycle
	task automatic acc(input logic w, input logic [11:0] a, input logic [1:0] be, input logic [15:0] v);
		cfg_sel = 1;
		cfg_write = w;
		cfg_addr = a;
		cfg_be = be;
		cfg_wdata = v;
		reg_q.push_back((w || a != 12'h050) ? 16'h0000 : img());
		if (w && a == 12'h050 && be[1]) m_mode = v[9];
		if (w && a == 12'h050 && be[0]) {m_sub, m_first} = {v[5:4], v[2:0]};
		tick();
		cfg_sel = 0;
		tick();
	endtask
	// One wait lookup, then an idle cycle
	task automatic look(input logic f);
		access_req = 1;
		access_first = f;
		wait_q.push_back(16'((f || !m_mode) ? m_first : {1'h0, m_sub}));
		tick();
		access_req = 0;
		tick();
	endtask
	task automatic results();
		if (reg_q.size() != 0 || wait_q.size() != 0) mismatches++;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Result watcher takes the oldest note per answer
	always @(posedge ref_clk) begin
		if (cfg_ack === 1'b1) check_read(reg_q.size() ? reg_q.pop_front() : 16'hXXXX);
		if (wait_valid === 1'b1) check_wait(wait_q.size() ? wait_q.pop_front() : 16'hXXXX);
	end

	// Hang guard
	initial begin
		#100000;
		mismatches++;
		results();
	end

	// Main sequence
	initial begin
		repeat (6) @(posedge ref_clk);
		#2;
		nrst = 1;
		tick();
		acc(0, 12'h050, 2'h3, 16'h0000);
		// Every strap code captured on a supply rise
		for (int k = 0; k < 8; k++) begin
			pg_on = 0;
			repeat (2) tick();
			pg_on = 1;
			strap_set = 3'(k);
			repeat (3) tick();
			{m_loc, m_w} = 3'(k);
			check("strap outs", {13'h0, m_loc, !m_loc, m_w[1]}, {13'h0, boot_on_sdram, boot_on_gp, 1'(boot_width >> 1)});
			check("width", 16'(m_w == 2'h1), 16'(boot_width == brsc_pkg::BRSC_W16));
			acc(0, 12'h050, 2'h3, 16'h0000);
		end
		// Straps move without a rise, software tries the strapped bits
		strap_set = 3'h0;
		repeat (3) tick();
		acc(1, 12'h050, 2'h3, 16'h1C00);
		acc(0, 12'h050, 2'h3, 16'h0000);
		acc(1, 12'h054, 2'h3, 16'h0237);
		acc(0, 12'h054, 2'h3, 16'h0000);
		// Random settings, page and non-page lookups
		for (int j = 0; j < 8; j++) begin
			rnd = lfsr(rnd);
			d = {6'h0, rnd[2] ^ j[0], 3'h0, rnd[4:3], 1'h0, rnd[7:5]};
			acc(1, 12'h050, (j < 2) ? 2'(j + 1) : 2'h3, d);
			acc(0, 12'h050, 2'h3, 16'h0000);
			check("fields", 16'({m_mode, m_sub, m_first}), 16'({page_mode, subsequent_delay_field, first_delay_field}));
			look(1);
			look(0);
		end
		repeat (3) tick();
		results();
	end
endmodule
